// >>> core/oca_alert_regs.sv
// smbus register bank with overcurrent thresholds, control words and alert timing
`include "oca_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module oca_alert_regs #(
    parameter logic [16:0] DEB1_CYC      = 17'(`OCA_DEB1_NS / `OCA_CLK_NS),
    parameter logic [16:0] DEB2_CYC      = 17'(`OCA_DEB2_NS / `OCA_CLK_NS),
    parameter logic [16:0] DEB3_CYC      = 17'(`OCA_DEB3_NS / `OCA_CLK_NS),
    parameter logic [23:0] HOLD_UNIT_CYC = 24'(`OCA_HOLD_UNIT_NS / `OCA_CLK_NS),
    parameter logic [6:0]  SLAVE_ADDR    = `OCA_SLAVE_ADDR
) (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic                scl_in,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_oe_n,
    input  wire logic [15:0]         adapter_current_ma,
    input  wire logic [15:0]         system_current_ma,
    output logic                     alert_n,
    output oca_pkg::oca_ctrl0_s      ctrl0,
    output oca_pkg::oca_word_t       ctrl1_word,
    output oca_pkg::oca_word_t       ctrl2_word,
    output oca_pkg::oca_word_t       ctrl3_word,
    output oca_pkg::oca_word_t       ctrl4_word
);

    oca_pkg::oca_smb_ev_s    ev;
    oca_pkg::oca_smb_state_e state_r;
    logic [7:0]              rx_sh_r;
    logic [7:0]              tx_sh_r;
    logic [3:0]              bit_cnt_r;
    logic [1:0]              byte_idx_r;
    logic                    rd_mode_r;
    logic                    mack_ok_r;
    logic                    cmd_ok_r;
    logic [7:0]              cmd_r;
    logic [7:0]              lo_r;
    logic                    wr_stb_r;
    oca_pkg::oca_word_t      wr_data_r;
    logic                    sda_oe_n_r;
    logic                    sda_out_r;
    oca_pkg::oca_word_t      adp_thr_r;
    oca_pkg::oca_word_t      sys_thr_r;
    oca_pkg::oca_ctrl0_s     ctrl0_r;
    oca_pkg::oca_word_t      ctrl1_r;
    oca_pkg::oca_word_t      ctrl2_r;
    oca_pkg::oca_word_t      ctrl3_r;
    oca_pkg::oca_word_t      ctrl4_r;
    oca_pkg::oca_word_t      rd_word;
    logic                    cmd_mapped;
    logic [7:0]              rx_byte;
    logic [5:0]              adp_code;
    logic [5:0]              sys_code;
    logic [16:0]             deb_cyc;
    logic [23:0]             hold_cyc;
    logic                    adp_qual;
    logic                    sys_qual;
    logic [23:0]             hold_cnt_r;
    logic                    alert_n_r;

    oca_bus_edges u_edges (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .scl_in (scl_in),
        .sda_in (sda_in),
        .ev     (ev)
    );

    assign rx_byte = {rx_sh_r[6:0], ev.sda};

    always_comb
    begin
        cmd_mapped = 1'b1;
        rd_word    = 16'h0000;
        case (cmd_r)
            `OCA_CMD_CTRL0:   rd_word = ctrl0_r;
            `OCA_CMD_CTRL1:   rd_word = ctrl1_r;
            `OCA_CMD_CTRL2:   rd_word = ctrl2_r;
            `OCA_CMD_CTRL3:   rd_word = ctrl3_r;
            `OCA_CMD_CTRL4:   rd_word = ctrl4_r;
            `OCA_CMD_ADP_THR: rd_word = adp_thr_r;
            `OCA_CMD_SYS_THR: rd_word = sys_thr_r;
            default:          cmd_mapped = 1'b0;
        endcase
    end

    // byte-level smbus slave; no clock stretching, so every byte is acked or refused at once
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r    <= oca_pkg::OCA_IDLE;
            rx_sh_r    <= 8'h00;
            tx_sh_r    <= 8'h00;
            bit_cnt_r  <= 4'h0;
            byte_idx_r <= 2'h0;
            rd_mode_r  <= 1'b0;
            mack_ok_r  <= 1'b0;
            cmd_ok_r   <= 1'b0;
            cmd_r      <= 8'h00;
            lo_r       <= 8'h00;
            wr_stb_r   <= 1'b0;
            wr_data_r  <= 16'h0000;
            sda_oe_n_r <= 1'b1;
        end
        else
        begin
            wr_stb_r <= 1'b0;
            if (ev.stop)
            begin
                state_r    <= oca_pkg::OCA_IDLE;
                sda_oe_n_r <= 1'b1;
                cmd_ok_r   <= 1'b0;
            end
            else if (ev.start)
            begin
                // a repeated start keeps the command so a read-word can follow
                state_r    <= oca_pkg::OCA_RX;
                bit_cnt_r  <= 4'h0;
                byte_idx_r <= 2'h0;
                rd_mode_r  <= 1'b0;
                sda_oe_n_r <= 1'b1;
            end
            else
            begin
                case (state_r)
                    oca_pkg::OCA_RX:
                    begin
                        if (ev.scl_rise && bit_cnt_r != 4'h8)
                        begin
                            rx_sh_r   <= rx_byte;
                            bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
                        end
                        else if (ev.scl_fall && bit_cnt_r == 4'h8)
                        begin
                            bit_cnt_r <= 4'h0;
                            state_r   <= oca_pkg::OCA_WAIT;
                            case (byte_idx_r)
                                2'h0:
                                begin
                                    if (rx_sh_r[7:1] == SLAVE_ADDR && (!rx_sh_r[0] || cmd_ok_r))
                                    begin
                                        rd_mode_r  <= rx_sh_r[0];
                                        byte_idx_r <= 2'h1;
                                        sda_oe_n_r <= 1'b0;
                                        state_r    <= oca_pkg::OCA_ACK;
                                    end
                                end
                                2'h1:
                                begin
                                    cmd_r <= rx_sh_r;
                                    if (rx_sh_r == `OCA_CMD_CTRL0 || rx_sh_r == `OCA_CMD_CTRL1 ||
                                        rx_sh_r == `OCA_CMD_CTRL2 || rx_sh_r == `OCA_CMD_CTRL3 ||
                                        rx_sh_r == `OCA_CMD_CTRL4 || rx_sh_r == `OCA_CMD_ADP_THR ||
                                        rx_sh_r == `OCA_CMD_SYS_THR)
                                    begin
                                        cmd_ok_r   <= 1'b1;
                                        byte_idx_r <= 2'h2;
                                        sda_oe_n_r <= 1'b0;
                                        state_r    <= oca_pkg::OCA_ACK;
                                    end
                                end
                                2'h2:
                                begin
                                    lo_r       <= rx_sh_r;
                                    byte_idx_r <= 2'h3;
                                    sda_oe_n_r <= 1'b0;
                                    state_r    <= oca_pkg::OCA_ACK;
                                end
                                default:
                                begin
                                    wr_data_r  <= {rx_sh_r, lo_r};
                                    wr_stb_r   <= 1'b1;
                                    cmd_ok_r   <= 1'b0;
                                    sda_oe_n_r <= 1'b0;
                                    state_r    <= oca_pkg::OCA_ACK;
                                    byte_idx_r <= 2'h0;
                                end
                            endcase
                        end
                    end
                    oca_pkg::OCA_ACK:
                    begin
                        if (ev.scl_fall)
                        begin
                            bit_cnt_r <= 4'h0;
                            if (rd_mode_r)
                            begin
                                sda_oe_n_r <= rd_word[7];
                                tx_sh_r    <= {rd_word[6:0], 1'b0};
                                state_r    <= oca_pkg::OCA_TX;
                            end
                            else
                            begin
                                sda_oe_n_r <= 1'b1;
                                state_r    <= (byte_idx_r == 2'h0) ? oca_pkg::OCA_WAIT : oca_pkg::OCA_RX;
                            end
                        end
                    end
                    oca_pkg::OCA_TX:
                    begin
                        if (ev.scl_rise)
                        begin
                            bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
                        end
                        else if (ev.scl_fall && bit_cnt_r == 4'h8)
                        begin
                            sda_oe_n_r <= 1'b1;
                            state_r    <= oca_pkg::OCA_MACK;
                        end
                        else if (ev.scl_fall)
                        begin
                            sda_oe_n_r <= tx_sh_r[7];
                            tx_sh_r    <= {tx_sh_r[6:0], 1'b0};
                        end
                    end
                    oca_pkg::OCA_MACK:
                    begin
                        if (ev.scl_rise)
                        begin
                            mack_ok_r <= ~ev.sda;
                        end
                        else if (ev.scl_fall && mack_ok_r && byte_idx_r == 2'h1)
                        begin
                            // low byte went out and the host wants the high byte
                            byte_idx_r <= 2'h2;
                            bit_cnt_r  <= 4'h0;
                            sda_oe_n_r <= rd_word[15];
                            tx_sh_r    <= {rd_word[14:8], 1'b0};
                            state_r    <= oca_pkg::OCA_TX;
                        end
                        else if (ev.scl_fall)
                        begin
                            state_r <= oca_pkg::OCA_WAIT;
                        end
                    end
                    default:
                    begin
                        sda_oe_n_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    // open-drain line: only ever pulled low
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sda_out_r <= 1'b0;
        end
        else
        begin
            sda_out_r <= 1'b0;
        end
    end

    // any value is accepted; only the weighted field is kept, saturated at its maximum
    assign adp_code = (wr_data_r[`OCA_ADP_FLD_MSB:`OCA_ADP_FLD_LSB] > `OCA_THR_MAX_CODE) ?
                      `OCA_THR_MAX_CODE : wr_data_r[`OCA_ADP_FLD_MSB:`OCA_ADP_FLD_LSB];
    assign sys_code = (wr_data_r[`OCA_SYS_FLD_MSB:`OCA_SYS_FLD_LSB] > `OCA_THR_MAX_CODE) ?
                      `OCA_THR_MAX_CODE : wr_data_r[`OCA_SYS_FLD_MSB:`OCA_SYS_FLD_LSB];

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adp_thr_r <= `OCA_ADP_THR_RST;
            sys_thr_r <= `OCA_SYS_THR_RST;
        end
        else if (wr_stb_r && cmd_r == `OCA_CMD_ADP_THR)
        begin
            adp_thr_r <= {3'h0, adp_code, 7'h00};
        end
        else if (wr_stb_r && cmd_r == `OCA_CMD_SYS_THR)
        begin
            sys_thr_r <= {2'h0, sys_code, 8'h00};
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl0_r <= `OCA_CTRL_RST;
            ctrl1_r <= `OCA_CTRL_RST;
            ctrl2_r <= `OCA_CTRL_RST;
            ctrl3_r <= `OCA_CTRL_RST;
            ctrl4_r <= `OCA_CTRL_RST;
        end
        else if (wr_stb_r)
        begin
            case (cmd_r)
                `OCA_CMD_CTRL0:
                begin
                    ctrl0_r        <= wr_data_r;
                    ctrl0_r.unused <= 2'h0;
                end
                `OCA_CMD_CTRL1: ctrl1_r <= wr_data_r;
                `OCA_CMD_CTRL2: ctrl2_r <= wr_data_r;
                `OCA_CMD_CTRL3: ctrl3_r <= wr_data_r;
                `OCA_CMD_CTRL4: ctrl4_r <= wr_data_r;
                default:        ctrl1_r <= ctrl1_r;
            endcase
        end
    end

    always_comb
    begin
        case (ctrl2_r[`OCA_DEB_MSB:`OCA_DEB_LSB])
            2'h0:    deb_cyc = `OCA_DEB0_CYC;
            2'h1:    deb_cyc = DEB1_CYC;
            2'h2:    deb_cyc = DEB2_CYC;
            default: deb_cyc = DEB3_CYC;
        endcase
    end

    assign hold_cyc = 24'(HOLD_UNIT_CYC * 24'({21'h0, ctrl2_r[`OCA_HOLD_MSB:`OCA_HOLD_LSB]} + 24'h1));

    oca_debounce u_adp_deb (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .current_ma (adapter_current_ma),
        .thresh_ma  (adp_thr_r),
        .deb_cyc    (deb_cyc),
        .qual_r     (adp_qual)
    );

    oca_debounce u_sys_deb (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .current_ma (system_current_ma),
        .thresh_ma  (sys_thr_r),
        .deb_cyc    (deb_cyc),
        .qual_r     (sys_qual)
    );

    // hold restarts every cycle the condition stands, so release needs both hold done and current no longer above its threshold
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alert_n_r  <= 1'b1;
            hold_cnt_r <= 24'h0;
        end
        else if (adp_qual || sys_qual)
        begin
            alert_n_r  <= 1'b0;
            hold_cnt_r <= 24'(hold_cyc - 24'h1);
        end
        else if (hold_cnt_r != 24'h0)
        begin
            hold_cnt_r <= 24'(hold_cnt_r - 24'h1);
        end
        else
        begin
            alert_n_r <= 1'b1;
        end
    end

    assign sda_out    = sda_out_r;
    assign sda_oe_n   = sda_oe_n_r;
    assign alert_n    = alert_n_r;
    assign ctrl0      = ctrl0_r;
    assign ctrl1_word = ctrl1_r;
    assign ctrl2_word = ctrl2_r;
    assign ctrl3_word = ctrl3_r;
    assign ctrl4_word = ctrl4_r;

endmodule

`default_nettype wire

// >>> core/oca_bus_edges.sv
// serial bus line edge and start/stop condition detector
`timescale 1ns/1ps
`default_nettype none

module oca_bus_edges (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output oca_pkg::oca_smb_ev_s   ev
);

    logic scl_q_r;
    logic sda_q_r;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
        end
    end

    always_comb
    begin
        ev.start    = scl_in & scl_q_r & sda_q_r & ~sda_in;
        ev.stop     = scl_in & scl_q_r & ~sda_q_r & sda_in;
        ev.scl_rise = scl_in & ~scl_q_r;
        ev.scl_fall = ~scl_in & scl_q_r;
        ev.sda      = sda_in;
    end

endmodule

`default_nettype wire

// >>> core/oca_consts.svh
// register offsets, field positions, reset values and timing counts of the overcurrent alert block
`ifndef OCA_CONSTS_SVH
`define OCA_CONSTS_SVH

`define OCA_CMD_CTRL0        8'h39
`define OCA_CMD_CTRL1        8'h3C
`define OCA_CMD_CTRL2        8'h3D
`define OCA_CMD_ADP_THR      8'h47
`define OCA_CMD_SYS_THR      8'h48
`define OCA_CMD_CTRL3        8'h4C
`define OCA_CMD_CTRL4        8'h4E

`define OCA_ADP_THR_RST      16'h0C00
`define OCA_SYS_THR_RST      16'h1000
`define OCA_CTRL_RST         16'h0000
`define OCA_THR_MAX_CODE     6'h32

`define OCA_ADP_FLD_LSB      7
`define OCA_ADP_FLD_MSB      12
`define OCA_SYS_FLD_LSB      8
`define OCA_SYS_FLD_MSB      13

`define OCA_DEB_MSB          10
`define OCA_DEB_LSB          9
`define OCA_HOLD_MSB         8
`define OCA_HOLD_LSB         6

`define OCA_CLK_NS           10
`define OCA_DEB0_NS          7000
`define OCA_DEB1_NS          100000
`define OCA_DEB2_NS          500000
`define OCA_DEB3_NS          1000000
`define OCA_HOLD_UNIT_NS     1000000
`define OCA_DEB0_CYC         17'((`OCA_DEB0_NS + `OCA_CLK_NS - 1) / `OCA_CLK_NS)

`define OCA_SLAVE_ADDR       7'h09

`endif

// >>> core/oca_debounce.sv
// one overcurrent comparator with its assertion debounce
`timescale 1ns/1ps
`default_nettype none

module oca_debounce (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [15:0] current_ma,
    input  wire logic [15:0] thresh_ma,
    input  wire logic [16:0] deb_cyc,
    output logic             qual_r
);

    logic [16:0] cnt_r;
    logic        over;

    // thresholds are stored so that the register value equals the limit in mA
    assign over = current_ma > thresh_ma;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r  <= 17'h0;
            qual_r <= 1'b0;
        end
        else if (!over)
        begin
            cnt_r  <= 17'h0;
            qual_r <= 1'b0;
        end
        else if (cnt_r >= 17'(deb_cyc - 17'h1))
        begin
            qual_r <= 1'b1;
        end
        else
        begin
            cnt_r <= 17'(cnt_r + 17'h1);
        end
    end

endmodule

`default_nettype wire

// >>> core/oca_pkg.sv
// types shared by the overcurrent alert register block
package oca_pkg;

    typedef logic [15:0] oca_word_t;

    typedef enum logic [2:0] {
        OCA_IDLE,
        OCA_RX,
        OCA_ACK,
        OCA_TX,
        OCA_MACK,
        OCA_WAIT
    } oca_smb_state_e;

    typedef struct packed {
        logic [2:0] fwd_ofs;
        logic [2:0] boost_ofs;
        logic [2:0] rev_ofs;
        logic [1:0] short_thr;
        logic [1:0] unused;
        logic       vin_loop_dis;
        logic       adapter_side_dis_en;
        logic       system_dis_en;
    } oca_ctrl0_s;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } oca_smb_ev_s;

endpackage

// >>> tb/oca_smb_host.sv
// smbus host model issuing word writes and word reads
`timescale 1ns/1ps
`default_nettype none
module oca_smb_host #(
    parameter logic [6:0] ADDR = 7'h09
) (
    input  wire logic mclk,
    input  wire logic sda_w,
    output logic      scl,
    output logic      sda_h
);
    initial
    begin
        scl = 1'b1;
        sda_h = 1'b1;
    end
    task automatic q(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // data moves only mid-low phase, each phase four cycles, so edges never coincide
    task automatic cbit(input logic b, output logic r);
        q(1);
        sda_h = b;
        q(3);
        scl = 1'b1;
        q(2);
        r = sda_w;
        q(2);
        scl = 1'b0;
    endtask
    // start when stp is 0, stop when 1
    task automatic cond(input logic stp);
        q(1);
        sda_h = ~stp;
        q(3);
        scl = 1'b1;
        q(4);
        sda_h = stp;
        q(4);
        if (!stp) scl = 1'b0;
    endtask
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) cbit(d[i], r);
        cbit(1'b1, r);
        ack = !r;
    endtask
    task automatic rx(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) cbit(1'b1, d[i]);
        cbit(last, r);
    endtask
    task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d, output logic ok);
        logic [3:0] a;
        cond(1'b0);
        tx({ADDR, 1'b0}, a[0]);
        tx(cmd, a[1]);
        tx(d[7:0], a[2]);
        tx(d[15:8], a[3]);
        cond(1'b1);
        ok = &a;
    endtask
    task automatic rd_word(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
        logic [2:0] a;
        cond(1'b0);
        tx({ADDR, 1'b0}, a[0]);
        tx(cmd, a[1]);
        cond(1'b0);
        tx({ADDR, 1'b1}, a[2]);
        rx(1'b0, d[7:0]);
        rx(1'b1, d[15:8]);
        cond(1'b1);
        ok = &a;
    endtask
endmodule
`default_nettype wire

// >>> tb/oca_sva.sv
// port assertions of the overcurrent alert register block
`include "oca_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module oca_sva #(
    parameter logic [16:0] DEB1_CYC      = 17'h00014,
    parameter logic [16:0] DEB2_CYC      = 17'h0001E,
    parameter logic [16:0] DEB3_CYC      = 17'h00028,
    parameter logic [23:0] HOLD_UNIT_CYC = 24'h00000A
) (
    input wire logic                mclk,
    input wire logic                rst_n,
    input wire logic                scl_in,
    input wire logic                sda_oe_n,
    input wire logic [15:0]         adapter_current_ma,
    input wire logic [15:0]         system_current_ma,
    input wire logic                alert_n,
    input wire oca_pkg::oca_ctrl0_s ctrl0,
    input wire oca_pkg::oca_word_t  ctrl1_word,
    input wire oca_pkg::oca_word_t  ctrl2_word,
    input wire oca_pkg::oca_word_t  ctrl3_word,
    input wire oca_pkg::oca_word_t  ctrl4_word
);
    logic        cur_nz;
    logic [23:0] nz_cnt_r;
    logic [23:0] low_cnt_r;
    logic [23:0] deb_need;
    logic [23:0] hold_need;
    // any nonzero current can exceed a zero threshold, so this is the weakest cause of an alert
    assign cur_nz    = (adapter_current_ma != 16'h0000) || (system_current_ma != 16'h0000);
    assign deb_need  = ctrl2_word[10:9] == 2'h0 ? 24'(`OCA_DEB0_CYC) : ctrl2_word[10:9] == 2'h1 ? 24'(DEB1_CYC)
                     : ctrl2_word[10:9] == 2'h2 ? 24'(DEB2_CYC) : 24'(DEB3_CYC);
    assign hold_need = HOLD_UNIT_CYC * (24'(ctrl2_word[8:6]) + 24'h000001);
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n) nz_cnt_r <= 24'h000000;
        else nz_cnt_r <= cur_nz ? nz_cnt_r + 24'h000001 : 24'h000000;
    end
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n) low_cnt_r <= 24'h000000;
        else low_cnt_r <= !alert_n ? low_cnt_r + 24'h000001 : 24'h000000;
    end
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_RST_VAL: assert property ($rose(rst_n) |-> alert_n && sda_oe_n && ctrl0 == 16'h0000)
        else $error("alert, bus or control word not at reset value");
    AST_UNUSED_ZERO: assert property (ctrl0.unused == 2'h0)
        else $error("unused control bits not zero");
    AST_OE_STABLE: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
        else $error("data line moved while bus clock high");
    AST_CTRL_SCL_LOW: assert property ($changed({ctrl0, ctrl1_word, ctrl2_word, ctrl3_word, ctrl4_word}) |-> !scl_in)
        else $error("control word changed outside a write");
    AST_DEBOUNCE: assert property ($fell(alert_n) |-> nz_cnt_r >= deb_need)
        else $error("alert asserted before debounce ran out");
    AST_HOLD: assert property ($rose(alert_n) |-> low_cnt_r >= hold_need)
        else $error("alert released before minimum hold");
    AST_QUIET: assert property (alert_n && !cur_nz && !$past(cur_nz) |=> alert_n)
        else $error("alert asserted with no current");
    AST_NO_EARLY: assert property ($rose(cur_nz) && alert_n |=> alert_n [*8])
        else $error("alert asserted right after current appeared");
    cover property ($fell(alert_n));
    cover property ($rose(alert_n));
    cover property ($fell(sda_oe_n));
endmodule
`default_nettype wire

// >>> tb/tb_oca_alert_regs.sv
// self-checking bench of the overcurrent alert register block
`include "oca_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_oca_alert_regs;
    logic                mclk, rst_n, scl, sda_h, sda_w, sda_out, sda_oe_n, alert_n, ok;
    logic [15:0]         adp_ma, sys_ma, rd;
    oca_pkg::oca_ctrl0_s ctrl0;
    oca_pkg::oca_word_t  c1, c2, c3, c4;
    logic [79:0]         outs;
    logic [7:0]          cw [5] = '{8'h39, 8'h3C, 8'h3D, 8'h4C, 8'h4E};
    logic [7:0]          tc [8] = '{8'h47, 8'h47, 8'h47, 8'h47, 8'h48, 8'h48, 8'h48, 8'h48};
    logic [15:0]         tw [8] = '{16'hFFFF, 16'h1980, 16'h1900, 16'hE0FF, 16'hFFFF, 16'h3300, 16'h3200, 16'hC1FF};
    logic [15:0]         te [8] = '{16'h1900, 16'h1900, 16'h1900, 16'h0080, 16'h3200, 16'h3200, 16'h3200, 16'h0100};
    int                  n_errors = 0;
    int                  checked = 0;
    assign sda_w = sda_h & (sda_oe_n | sda_out);
    assign outs  = {c4, c3, c2, c1, ctrl0};
    oca_alert_regs #(.DEB1_CYC(17'h00014), .DEB2_CYC(17'h0001E), .DEB3_CYC(17'h00028), .HOLD_UNIT_CYC(24'h00000A)) uut (
        .mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .adapter_current_ma(adp_ma), .system_current_ma(sys_ma), .alert_n(alert_n), .ctrl0(ctrl0),
        .ctrl1_word(c1), .ctrl2_word(c2), .ctrl3_word(c3), .ctrl4_word(c4));
    oca_smb_host #(.ADDR(7'h09)) host (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda_h(sda_h));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.wr_word(a, d, ok);
        chk("write ack", 16'h0001, 16'(ok));
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        host.rd_word(a, rd, ok);
        chk("read ack", 16'h0001, 16'(ok));
        chk("read data", e, rd);
    endtask
    task automatic setc(input logic s, input logic [15:0] v);
        if (s) sys_ma = v;
        else adp_ma = v;
    endtask
    task automatic al(input logic e);
        chk("alert_n", 16'(e), 16'(alert_n));
    endtask
    // odd cases use the system side; hold is ten cycles per code step
    task automatic alert_case(input int k);
        int          n;
        logic [15:0] th;
        n = (k == 0) ? int'(`OCA_DEB0_CYC) : 10 + 10 * k;
        th = k[0] ? 16'h0100 : 16'h0080;
        wr(8'h3D, {5'h00, 2'(k), 3'(k), 6'h00});
        setc(k[0], th);
        repeat (n + 3) @(negedge mclk);
        al(1'b1);
        setc(k[0], th + 16'h0001);
        repeat (n - 1) @(negedge mclk);
        setc(k[0], 16'h0000);
        repeat (5) @(negedge mclk);
        al(1'b1);
        setc(k[0], th + 16'h0001);
        repeat (n) @(negedge mclk);
        al(1'b1);
        @(negedge mclk);
        al(1'b0);
        repeat (10 * k + 30) @(negedge mclk);
        al(1'b0);
        setc(k[0], 16'h0000);
        repeat (10 * k + 8) @(negedge mclk);
        al(1'b0);
        repeat (8) @(negedge mclk);
        al(1'b1);
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        #1000000;
        n_errors++;
        final_report();
    end
    initial
    begin
        rst_n = 1'b0;
        adp_ma = 16'h0000;
        sys_ma = 16'h0000;
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        rdc(8'h47, 16'h0C00);
        rdc(8'h48, 16'h1000);
        chk("ctrl0 reset", 16'h0000, ctrl0);
        chk("sda_out", 16'h0000, 16'(sda_out));
        for (int i = 0; i < 5; i++)
        begin
            wr(cw[i], 16'h85DE ^ (16'h1111 * 16'(i)));
            rdc(cw[i], (16'h85DE ^ (16'h1111 * 16'(i))) & (i == 0 ? 16'hFFE7 : 16'hFFFF));
            chk("control port", (16'h85DE ^ (16'h1111 * 16'(i))) & (i == 0 ? 16'hFFE7 : 16'hFFFF), outs[16 * i +: 16]);
        end
        chk("offsets", 16'h010B, {7'h00, ctrl0.fwd_ofs, ctrl0.boost_ofs, ctrl0.rev_ofs});
        chk("short threshold", 16'h0002, 16'(ctrl0.short_thr));
        chk("enables", 16'h0006, {13'h0000, ctrl0.vin_loop_dis, ctrl0.adapter_side_dis_en, ctrl0.system_dis_en});
        for (int i = 0; i < 8; i++)
        begin
            wr(tc[i], tw[i]);
            rdc(tc[i], te[i]);
        end
        host.wr_word(8'h40, 16'h1234, ok);
        chk("unmapped write ack", 16'h0000, 16'(ok));
        host.rd_word(8'h40, rd, ok);
        chk("unmapped read ack", 16'h0000, 16'(ok));
        for (int k = 0; k < 4; k++) alert_case(k);
        rst_n = 1'b0;
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        rdc(8'h47, 16'h0C00);
        chk("ctrl2 reset", 16'h0000, c2);
        final_report();
    end
endmodule
bind oca_alert_regs oca_sva #(.DEB1_CYC(DEB1_CYC), .DEB2_CYC(DEB2_CYC), .DEB3_CYC(DEB3_CYC), .HOLD_UNIT_CYC(HOLD_UNIT_CYC)) u_sva (
    .mclk(mclk), .rst_n(rst_n), .scl_in(scl_in), .sda_oe_n(sda_oe_n), .adapter_current_ma(adapter_current_ma),
    .system_current_ma(system_current_ma), .alert_n(alert_n), .ctrl0(ctrl0), .ctrl1_word(ctrl1_word),
    .ctrl2_word(ctrl2_word), .ctrl3_word(ctrl3_word), .ctrl4_word(ctrl4_word));
`default_nettype wire
